//--- bench/gio_far_side.sv
// Core fabric clocks and pad level seen by one pin's I/O logic.
// Assumes clk is the system clock; run low parks both core clocks low.
`timescale 1ns/10ps
module gio_far_side (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic run,
    input  wire logic ext_level,
    input  wire logic pad_out,
    input  wire logic pad_oe,
    output logic      pad_in,
    output logic      in_capture_clk,
    output logic      out_launch_clk
);
    // =========================================================
    // Core clocks, each level at least two system clocks
    logic [2:0] div_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_q <= 3'h0;
        end else if (!run) begin
            div_q <= 3'h0;
        end else begin
            div_q <= div_q + 3'h1;
        end
    end

    assign in_capture_clk = div_q[1];
    assign out_launch_clk = div_q[2];

    // =========================================================
    // Pad wire: driven pin wins, else the board level
    assign pad_in = pad_oe ? pad_out : ext_level;

endmodule : gio_far_side

//--- bench/gio_io_logic_test.sv
// Self-checking bench for the single-pin I/O logic block.
// Assumes gio_pkg and the far-side model are compiled first.
`timescale 1ns/10ps
module gio_io_logic_test;
    import gio_pkg::*;
    logic        clk, rst, psel, penable, pwrite, core_out, core_oe, ext_level, run, err;
    logic        pready, pslverr, in_capture_clk, out_launch_clk, core_in, bypass_input, pad_in, pad_out, pad_oe;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    int          num_errors = 0, check_count = 0, cycles = 0, ones;
    gio_cfg_t    cfg;

    gio_io_logic gio_io_logic_inst (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .in_capture_clk(in_capture_clk), .out_launch_clk(out_launch_clk), .core_out(core_out),
        .core_oe(core_oe), .core_in(core_in), .bypass_input(bypass_input), .pad_in(pad_in),
        .pad_out(pad_out), .pad_oe(pad_oe));
    gio_far_side gio_far_side_inst (.clk(clk), .rst(rst), .run(run), .ext_level(ext_level),
        .pad_out(pad_out), .pad_oe(pad_oe), .pad_in(pad_in), .in_capture_clk(in_capture_clk),
        .out_launch_clk(out_launch_clk));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            summarize();
        end
    end

    task summarize();
        if (num_errors == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : summarize

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // APB transfer: hold request until pready is seen high at a rising edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task setcfg(input gio_cfg_t c);
        apb(1'b1, GIO_CTRL_OFS, 32'(c));
    endtask : setcfg

    task wt(input int n);
        repeat (n) @(posedge clk);
    endtask : wt

    initial begin
        rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
        core_out = 1'b0; core_oe = 1'b0; ext_level = 1'b0; run = 1'b1;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        apb(1'b0, GIO_CTRL_OFS, 32'h0); chk(rd, 32'h0);
        apb(1'b0, 12'h008, 32'h0); chk({31'h0, err}, 32'h1);
        // Input mode, unregistered
        ext_level <= 1'b1; wt(6);
        chk(core_in, 1);
        chk({pad_oe, pad_out}, 0);
        // Registered input holds while the capture clock is parked
        cfg = GIO_CFG_RST; cfg.in_reg_en = 1'b1; cfg.in_edge = GIO_EDGE_FALL; setcfg(cfg);
        wt(20); run <= 1'b0; wt(4); ext_level <= 1'b0; wt(10);
        chk(core_in, 1);
        run <= 1'b1; wt(20);
        chk(core_in, 0);
        // Bypass path is never registered, even with the clock parked
        cfg.bypass_sel = 1'b1; setcfg(cfg); run <= 1'b0; ext_level <= 1'b1; wt(6);
        chk(bypass_input, 1);
        chk(core_in, 0);
        ext_level <= 1'b0; wt(6);
        chk(bypass_input, 0);
        run <= 1'b1;
        // Output mode, unregistered then registered and inverted
        cfg = GIO_CFG_RST; cfg.mode = GIO_MODE_OUT; setcfg(cfg); core_out <= 1'b1; wt(6);
        chk({pad_oe, pad_out, core_in}, 3'b110);
        cfg.out_edge = GIO_EDGE_FALL;
        cfg.out_reg_en = 1'b1; cfg.out_invert = 1'b1; setcfg(cfg); wt(20);
        chk(pad_out, 0);
        // Bidirectional: registered drive-enable and input, plain output
        cfg = GIO_CFG_RST; cfg.mode = GIO_MODE_BIDIR; cfg.in_reg_en = 1'b1; cfg.oe_reg_en = 1'b1;
        cfg.oe_edge = GIO_EDGE_FALL; setcfg(cfg); core_oe <= 1'b0; ext_level <= 1'b1; wt(20);
        chk(pad_oe, 0);
        chk(core_in, 1);
        core_oe <= 1'b1; core_out <= 1'b0; wt(20);
        chk({pad_oe, pad_out}, 2'b10);
        chk(core_in, 0);
        apb(1'b0, GIO_STATUS_OFS, 32'h0); chk(rd[3], 1);
        // Bidirectional: plain input, registered output
        cfg.in_reg_en  = 1'b0;
        cfg.out_reg_en = 1'b1;
        setcfg(cfg);
        core_out <= 1'b1;
        wt(20);
        chk({pad_oe, pad_out, core_in}, 3'b111);
        // Clock output mode toggles the pad
        cfg = GIO_CFG_RST; cfg.mode = GIO_MODE_CLKO; setcfg(cfg); wt(6); ones = 0;
        repeat (16) begin
            @(posedge clk);
            ones += int'(pad_out === 1'b1);
        end
        chk(ones, 8);
        summarize();
    end
endmodule : gio_io_logic_test

//--- rtl/gio_io_logic.sv
// I/O logic of one general-purpose pin between core fabric and pad buffer.
// Assumes APB master on clk; capture/launch clocks and pad arrive asynchronously.
// How it works
// - Input mode drives only pad-to-core path
// - Bypass path carries pad without capture register
// - Bypass feeds other block, not core input
// - Output mode drives only core-to-pad path
// - Optional inversion of output register value
// - Bidir: capture clock input, launch clock outputs
// - Each register picks its own edge
// - Input and output registering chosen separately
// - Clock output mode drives launch clock out
// - Three registers: capture, output, drive-enable
`timescale 1ns/10ps
module gio_io_logic (
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic                in_capture_clk,
    input  wire logic                out_launch_clk,
    input  wire logic                core_out,
    input  wire logic                core_oe,
    output logic                     core_in,
    output logic                     bypass_input,
    input  wire logic                pad_in,
    output logic                     pad_out,
    output logic                     pad_oe
);
    import gio_pkg::*;

    // =========================================================
    // Helpers
    function automatic logic edge_hit(input logic sel, input logic now, input logic was);
        edge_hit = (sel == GIO_EDGE_FALL) ? (was & ~now) : (now & ~was);
    endfunction : edge_hit

    function automatic logic is_ctrl(input logic [11:0] a);
        is_ctrl = (a == GIO_CTRL_OFS);
    endfunction : is_ctrl

    function automatic logic is_status(input logic [11:0] a);
        is_status = (a == GIO_STATUS_OFS);
    endfunction : is_status

    // =========================================================
    // Synchronisers
    logic icap_s1_q;
    logic icap_s2_q;
    logic icap_s3_q;
    logic olch_s1_q;
    logic olch_s2_q;
    logic olch_s3_q;
    logic pad_s1_q;
    logic pad_s2_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            icap_s1_q <= 1'b0;
            icap_s2_q <= 1'b0;
            icap_s3_q <= 1'b0;
            olch_s1_q <= 1'b0;
            olch_s2_q <= 1'b0;
            olch_s3_q <= 1'b0;
            pad_s1_q  <= 1'b0;
            pad_s2_q  <= 1'b0;
        end else begin
            icap_s1_q <= in_capture_clk;
            icap_s2_q <= icap_s1_q;
            icap_s3_q <= icap_s2_q;
            olch_s1_q <= out_launch_clk;
            olch_s2_q <= olch_s1_q;
            olch_s3_q <= olch_s2_q;
            pad_s1_q  <= pad_in;
            pad_s2_q  <= pad_s1_q;
        end
    end

    // =========================================================
    // APB slave
    gio_cfg_t     cfg_q;
    gio_apb_rsp_t rsp_q;
    gio_status_t  status;
    logic         in_cap_q;
    logic         out_reg_q;
    logic         oe_reg_q;
    logic         apb_first;
    logic         apb_done;
    logic         addr_ok;

    assign apb_first = psel & penable & ~rsp_q.pready;
    assign apb_done  = psel & penable & rsp_q.pready;
    assign addr_ok   = is_ctrl(paddr) || is_status(paddr);
    assign status    = '{oe_reg: oe_reg_q, out_reg: out_reg_q, in_cap: in_cap_q, pad_level: pad_s2_q};

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rsp_q <= '0;
        end else begin
            rsp_q.pready  <= apb_first;
            rsp_q.pslverr <= apb_first & ~addr_ok;
            if (apb_first & ~pwrite) begin
                if (is_ctrl(paddr)) begin
                    rsp_q.prdata <= {{(32 - GIO_CFG_W){1'b0}}, cfg_q};
                end else if (is_status(paddr)) begin
                    rsp_q.prdata <= {{(32 - GIO_STATUS_W){1'b0}}, status};
                end else begin
                    rsp_q.prdata <= 32'h0000_0000;
                end
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg_q <= GIO_CFG_RST;
        end else if (apb_done && pwrite && is_ctrl(paddr)) begin
            cfg_q <= gio_cfg_t'(pwdata[GIO_CFG_W-1:0]);
        end
    end

    assign prdata  = rsp_q.prdata;
    assign pready  = rsp_q.pready;
    assign pslverr = rsp_q.pslverr;

    // =========================================================
    // Capture, output and drive-enable registers
    logic in_fire;
    logic out_fire;
    logic oe_fire;

    assign in_fire  = edge_hit(cfg_q.in_edge, icap_s2_q, icap_s3_q);
    assign out_fire = edge_hit(cfg_q.out_edge, olch_s2_q, olch_s3_q);
    assign oe_fire  = edge_hit(cfg_q.oe_edge, olch_s2_q, olch_s3_q);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            in_cap_q <= 1'b0;
        end else if (in_fire) begin
            in_cap_q <= pad_s2_q;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            out_reg_q <= 1'b0;
        end else if (out_fire) begin
            out_reg_q <= core_out;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            oe_reg_q <= 1'b0;
        end else if (oe_fire) begin
            oe_reg_q <= core_oe;
        end
    end

    // =========================================================
    // Path selection
    logic out_val;
    logic oe_val;
    logic in_val;

    always_comb begin
        out_val = cfg_q.out_reg_en ? (out_reg_q ^ cfg_q.out_invert) : core_out;
        oe_val  = cfg_q.oe_reg_en ? oe_reg_q : core_oe;
        in_val  = cfg_q.in_reg_en ? in_cap_q : pad_s2_q;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pad_out <= 1'b0;
            pad_oe  <= 1'b0;
        end else begin
            case (cfg_q.mode)
                GIO_MODE_OUT: begin
                    pad_out <= out_val;
                    pad_oe  <= 1'b1;
                end
                GIO_MODE_BIDIR: begin
                    pad_out <= oe_val ? out_val : 1'b0;
                    pad_oe  <= oe_val;
                end
                GIO_MODE_CLKO: begin
                    pad_out <= olch_s2_q;
                    pad_oe  <= 1'b1;
                end
                default: begin
                    pad_out <= 1'b0;
                    pad_oe  <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            core_in      <= 1'b0;
            bypass_input <= 1'b0;
        end else begin
            case (cfg_q.mode)
                GIO_MODE_IN: begin
                    core_in      <= cfg_q.bypass_sel ? 1'b0 : in_val;
                    bypass_input <= cfg_q.bypass_sel & pad_s2_q;
                end
                GIO_MODE_BIDIR: begin
                    core_in      <= in_val;
                    bypass_input <= 1'b0;
                end
                default: begin
                    core_in      <= 1'b0;
                    bypass_input <= 1'b0;
                end
            endcase
        end
    end

    // =========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_mode_in;
        cfg_q.mode == GIO_MODE_IN;
    endsequence

    sequence s_mode_out_held;
        (cfg_q.mode == GIO_MODE_OUT && cfg_q.out_reg_en) [*2];
    endsequence

    sequence s_bidir_oe_reg;
        cfg_q.mode == GIO_MODE_BIDIR && cfg_q.oe_reg_en;
    endsequence

    sequence s_bidir_in_reg;
        cfg_q.mode == GIO_MODE_BIDIR && cfg_q.in_reg_en;
    endsequence

    AST_INPUT_NO_DRIVE: assert property (s_mode_in ##1 s_mode_in |-> !pad_oe)
        else $error("pad driven in input mode");
    AST_BYPASS_DIRECT: assert property (cfg_q.mode == GIO_MODE_IN && cfg_q.bypass_sel
                                        |=> bypass_input == $past(pad_s2_q))
        else $error("bypass path does not follow pad");
    AST_BYPASS_NOT_CORE: assert property (cfg_q.mode == GIO_MODE_IN && cfg_q.bypass_sel |=> !core_in)
        else $error("core input active while bypass selected");
    AST_OUT_CAPTURE: assert property (out_fire |=> out_reg_q == $past(core_out))
        else $error("output register missed launch edge");
    AST_OUT_INVERT: assert property (s_mode_out_held |-> pad_out == $past(out_reg_q ^ cfg_q.out_invert))
        else $error("inverted output value wrong");
    AST_IN_CAPTURE: assert property (in_fire |=> in_cap_q == $past(pad_s2_q))
        else $error("capture register missed capture edge");
    AST_OE_EDGE: assert property (oe_fire |=> oe_reg_q == $past(core_oe))
        else $error("drive-enable register missed its edge");
    AST_IN_UNREG: assert property (cfg_q.mode == GIO_MODE_BIDIR && !cfg_q.in_reg_en
                                   |=> core_in == $past(pad_s2_q))
        else $error("unregistered input path wrong");
    AST_CLK_OUT: assert property (cfg_q.mode == GIO_MODE_CLKO |=> pad_oe && pad_out == $past(olch_s2_q))
        else $error("clock output path wrong");
    AST_UNDRIVEN: assert property (!pad_oe |-> !pad_out)
        else $error("pad value present while undriven");
    AST_APB_ANSWER: assert property (psel && penable && !pready |=> pready ##1 !pready)
        else $error("apb answer timing wrong");
    AST_APB_ERROR: assert property (apb_first && !addr_ok |=> pready && pslverr)
        else $error("unmapped access not flagged");
    AST_CFG_WRITE: assert property (apb_done && pwrite && is_ctrl(paddr)
                                    |=> cfg_q == $past(pwdata[GIO_CFG_W-1:0]))
        else $error("control write not stored");

    // =========================================================
    // Path checks
    AST_OUT_DRIVE: assert property (cfg_q.mode == GIO_MODE_OUT |=> pad_oe)
        else $error("pad not driven in output mode");
    AST_OUT_PLAIN: assert property (cfg_q.mode == GIO_MODE_OUT && !cfg_q.out_reg_en
                                    |=> pad_out == $past(core_out))
        else $error("unregistered output path wrong");
    AST_CORE_IN_QUIET: assert property (cfg_q.mode == GIO_MODE_OUT || cfg_q.mode == GIO_MODE_CLKO
                                        |=> !core_in)
        else $error("core input active in a driving mode");
    AST_BYPASS_QUIET: assert property (!(cfg_q.mode == GIO_MODE_IN && cfg_q.bypass_sel)
                                       |=> !bypass_input)
        else $error("bypass path active while not selected");
    AST_IN_PLAIN: assert property (cfg_q.mode == GIO_MODE_IN && !cfg_q.in_reg_en && !cfg_q.bypass_sel
                                   |=> core_in == $past(pad_s2_q))
        else $error("unregistered input mode path wrong");
    AST_IN_REG_PATH: assert property (cfg_q.mode == GIO_MODE_IN && cfg_q.in_reg_en && !cfg_q.bypass_sel
                                      |=> core_in == $past(in_cap_q))
        else $error("registered input mode path wrong");
    AST_BIDIR_OE_REG: assert property (s_bidir_oe_reg |=> pad_oe == $past(oe_reg_q))
        else $error("registered drive-enable not presented");
    AST_BIDIR_IN_REG: assert property (s_bidir_in_reg |=> core_in == $past(in_cap_q))
        else $error("registered bidirectional input wrong");
    AST_IN_HOLD: assert property (!in_fire |=> $stable(in_cap_q))
        else $error("capture register changed without edge");
    AST_OUT_HOLD: assert property (!out_fire |=> $stable(out_reg_q))
        else $error("output register changed without edge");
    AST_OE_HOLD: assert property (!oe_fire |=> $stable(oe_reg_q))
        else $error("drive-enable register changed without edge");

endmodule : gio_io_logic

//--- rtl/gio_pkg.sv
// Constants and types for the single-pin I/O logic block.
// Assumes one system clock; all core-side clocks arrive as sampled levels.
package gio_pkg;

    // =========================================================
    // Register map
    localparam logic [11:0] GIO_CTRL_OFS   = 12'h000;
    localparam logic [11:0] GIO_STATUS_OFS = 12'h004;

    // =========================================================
    // Modes and edges
    typedef enum logic [1:0] {
        GIO_MODE_IN    = 2'b00,
        GIO_MODE_OUT   = 2'b01,
        GIO_MODE_BIDIR = 2'b10,
        GIO_MODE_CLKO  = 2'b11
    } gio_mode_t;

    localparam logic GIO_EDGE_RISE = 1'b0;
    localparam logic GIO_EDGE_FALL = 1'b1;

    // =========================================================
    // Control register layout, bit 9 down to bit 0
    typedef struct packed {
        logic      bypass_sel;
        logic      out_invert;
        logic      oe_edge;
        logic      out_edge;
        logic      in_edge;
        logic      oe_reg_en;
        logic      out_reg_en;
        logic      in_reg_en;
        gio_mode_t mode;
    } gio_cfg_t;

    localparam int       GIO_CFG_W   = 10;
    localparam gio_cfg_t GIO_CFG_RST = '{bypass_sel: 1'b0, out_invert: 1'b0, oe_edge: 1'b0,
                                         out_edge: 1'b0, in_edge: 1'b0, oe_reg_en: 1'b0,
                                         out_reg_en: 1'b0, in_reg_en: 1'b0, mode: GIO_MODE_IN};

    // Status register layout, bit 3 down to bit 0
    typedef struct packed {
        logic oe_reg;
        logic out_reg;
        logic in_cap;
        logic pad_level;
    } gio_status_t;

    localparam int GIO_STATUS_W = 4;

    // APB answer carried as one group
    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } gio_apb_rsp_t;

endpackage : gio_pkg
